/* File: hw/wbe_pkg.sv */
// Shared constants and carrier types for the write buffer error logger
package wbe_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned WBE_ADDR_W = 8;
  localparam int unsigned WBE_DATA_W = 8;
  localparam int unsigned WBE_NSRC   = 4;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [WBE_ADDR_W-1:0] WBE_OFS_FIRST = 8'h70;
  localparam logic [WBE_ADDR_W-1:0] WBE_OFS_NEXT  = 8'h72;
  localparam logic [WBE_ADDR_W-1:0] WBE_OFS_MASK  = 8'h74;

  // ==========================================================================
  // Field positions, one per error source
  // ==========================================================================
  localparam int unsigned WBE_BIT_FLUSH_MEM = 0;
  localparam int unsigned WBE_BIT_TO_CPU    = 1;
  localparam int unsigned WBE_BIT_LINE_WR   = 2;
  localparam int unsigned WBE_BIT_RMW_FILL  = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [WBE_NSRC-1:0]   WBE_LOG_RST  = 4'h0;
  localparam logic [WBE_NSRC-1:0]   WBE_MASK_RST = 4'h0;
  localparam logic [WBE_DATA_W-1:0] WBE_RD_IDLE  = 8'h00;
  localparam logic [WBE_DATA_W-WBE_NSRC-1:0] WBE_RSVD_VAL = 4'h0;

  // ==========================================================================
  // Error strobes, bit order equals register bit order
  // ==========================================================================
  typedef struct packed {
    logic rmw_fill;
    logic line_write;
    logic to_cpu;
    logic flush_mem;
  } wbe_err_t;

  // Register bus request
  typedef struct packed {
    logic [WBE_ADDR_W-1:0] addr;
    logic [WBE_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } wbe_req_t;

endpackage

/* File: hw/wbe_w1c_log.sv */
// Sticky write-one-to-clear log bits, reset only at power-up
`timescale 1ns/1ps
module wbe_w1c_log #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             pwr_rst,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clr_bits,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================================
  // One flag per bit
  // ==========================================================================
  // System reset is not wired here: the log must survive it
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic bit_reg;
      logic bit_next;
      // Set beats clear so an event in the clearing cycle is kept
      assign bit_next = set_bits[i] | (bit_reg & ~clr_bits[i]);
      always_ff @(posedge clk) begin
        if (pwr_rst) begin
          bit_reg <= rst_val[i];
        end else begin
          bit_reg <= bit_next;
        end
      end
      assign q[i] = bit_reg;
    end
  endgenerate

endmodule

/* File: hw/wbe_error_log.sv */
// Write buffer parity error first/next log and mask register bank
`timescale 1ns/1ps
module wbe_error_log (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           pwr_rst,
  input  wire wbe_pkg::wbe_req_t              reg_req,
  output logic      [wbe_pkg::WBE_DATA_W-1:0] reg_rdata,
  input  wire wbe_pkg::wbe_err_t              err_strobe,
  output wbe_pkg::wbe_err_t                   err_event
);

  localparam int unsigned NS = wbe_pkg::WBE_NSRC;

  // ==========================================================================
  // Register bus decode
  // ==========================================================================
  logic          sel_first;
  logic          sel_next;
  logic          sel_mask;
  logic          wr_first;
  logic          wr_next;
  logic          wr_mask;
  logic [NS-1:0] wdata_low;

  assign sel_first = reg_req.addr == wbe_pkg::WBE_OFS_FIRST;
  assign sel_next  = reg_req.addr == wbe_pkg::WBE_OFS_NEXT;
  assign sel_mask  = reg_req.addr == wbe_pkg::WBE_OFS_MASK;
  assign wr_first  = reg_req.wr & sel_first;
  assign wr_next   = reg_req.wr & sel_next;
  assign wr_mask   = reg_req.wr & sel_mask;
  // Upper bits are dropped so reserved positions never store
  assign wdata_low = reg_req.wdata[NS-1:0];

  // ==========================================================================
  // Mask register
  // ==========================================================================
  logic [NS-1:0] mask_reg;
  logic [NS-1:0] mask_next;

  assign mask_next = wr_mask ? wdata_low : mask_reg;

  // Only power-up clears it, system reset leaves it alone
  always_ff @(posedge clk) begin
    if (pwr_rst) begin
      mask_reg <= wbe_pkg::WBE_MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ==========================================================================
  // Recognition and routing
  // ==========================================================================
  logic [NS-1:0] src_bits;
  logic [NS-1:0] recog;
  logic [NS-1:0] first_q;
  logic [NS-1:0] next_q;
  logic          first_empty;
  logic [NS-1:0] first_set;
  logic [NS-1:0] next_set;
  logic [NS-1:0] first_clr;
  logic [NS-1:0] next_clr;

  assign src_bits    = err_strobe;
  assign recog       = src_bits & ~mask_reg;
  assign first_empty = first_q == wbe_pkg::WBE_LOG_RST;
  // Whole group of same-clock errors goes in while empty
  assign first_set   = first_empty ? recog : '0;
  // Any recognised error while the first log is occupied lands here
  assign next_set    = first_empty ? '0 : recog;
  assign first_clr   = wr_first ? wdata_low : '0;
  assign next_clr    = wr_next ? wdata_low : '0;

  // Bit positions follow the source struct order
  wbe_w1c_log #(
    .WIDTH (NS)
  ) u_first_log (
    .clk      (clk),
    .pwr_rst  (pwr_rst),
    .set_bits (first_set),
    .clr_bits (first_clr),
    .rst_val  (wbe_pkg::WBE_LOG_RST),
    .q        (first_q)
  );

  // Set wins over clear inside the log cell
  wbe_w1c_log #(
    .WIDTH (NS)
  ) u_next_log (
    .clk      (clk),
    .pwr_rst  (pwr_rst),
    .set_bits (next_set),
    .clr_bits (next_clr),
    .rst_val  (wbe_pkg::WBE_LOG_RST),
    .q        (next_q)
  );

  // ==========================================================================
  // Event output toward global log and message units
  // ==========================================================================
  logic [NS-1:0] event_reg;
  logic [NS-1:0] event_next;

  assign event_next = recog;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_reg <= '0;
    end else begin
      event_reg <= event_next;
    end
  end

  assign err_event = event_reg;

  // ==========================================================================
  // Read path, data only in the cycle after the strobe
  // ==========================================================================
  logic [NS-1:0]                  rd_low;
  logic [wbe_pkg::WBE_DATA_W-1:0] rdata_reg;
  logic [wbe_pkg::WBE_DATA_W-1:0] rdata_next;

  assign rd_low = sel_first ? first_q :
                  sel_next  ? next_q  :
                  sel_mask  ? mask_reg : '0;
  // Unmapped addresses read zero
  assign rdata_next = reg_req.rd ? {wbe_pkg::WBE_RSVD_VAL, rd_low}
                                 : wbe_pkg::WBE_RD_IDLE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= wbe_pkg::WBE_RD_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || pwr_rst);

  a_next_catches_later: assert property (
    (!first_empty && recog != '0) |=> ((next_q & $past(recog)) == $past(recog))
  ) else $error("later error missing from next log");

  a_next_w1c_clear: assert property (
    (wr_next && (next_set & wdata_low) == '0) |=>
      ((next_q & $past(wdata_low)) == '0)
  ) else $error("next log bit not cleared by write of one");

  a_next_zero_keeps: assert property (
    wr_next |=> (($past(next_q) & ~$past(wdata_low) & next_q)
                 == ($past(next_q) & ~$past(wdata_low)))
  ) else $error("next log bit lost on write of zero");

  a_rmw_bit_logs: assert property (
    (!first_empty && recog[wbe_pkg::WBE_BIT_RMW_FILL]) |=>
      next_q[wbe_pkg::WBE_BIT_RMW_FILL]
  ) else $error("partial write fill error not in bit 3");

  a_line_bit_logs: assert property (
    (!first_empty && recog[wbe_pkg::WBE_BIT_LINE_WR]) |=>
      next_q[wbe_pkg::WBE_BIT_LINE_WR]
  ) else $error("line write error not in bit 2");

  a_cpu_bit_logs: assert property (
    (!first_empty && recog[wbe_pkg::WBE_BIT_TO_CPU]) |=>
      next_q[wbe_pkg::WBE_BIT_TO_CPU]
  ) else $error("processor path error not in bit 1");

  a_flush_bit_logs: assert property (
    (!first_empty && recog[wbe_pkg::WBE_BIT_FLUSH_MEM]) |=>
      next_q[wbe_pkg::WBE_BIT_FLUSH_MEM]
  ) else $error("flush error not in bit 0");

  a_mask_blocks_all: assert property (
    ((src_bits & mask_reg) != '0 && !reg_req.wr) |=>
      ((err_event & $past(src_bits & mask_reg)) == '0) &&
      ((first_q & ~$past(first_q) & $past(src_bits & mask_reg)) == '0) &&
      ((next_q & ~$past(next_q) & $past(src_bits & mask_reg)) == '0)
  ) else $error("masked error was recognised");

  a_mask_survives_rst: assert property (
    @(posedge clk) disable iff (pwr_rst)
    (sys_rst && !reg_req.wr) |=> (mask_reg == $past(mask_reg))
  ) else $error("mask changed across system reset");

  // Logs keep capturing under system reset, so routed bits may still arrive
  a_next_survives_rst: assert property (
    @(posedge clk) disable iff (pwr_rst)
    (sys_rst && !reg_req.wr) |=>
      (next_q == ($past(next_q) | $past(next_set)))
  ) else $error("next log changed across system reset");

  a_mask_read_back: assert property (
    (reg_req.rd && sel_mask && !reg_req.wr) |=>
      (reg_rdata == {wbe_pkg::WBE_RSVD_VAL, $past(mask_reg)})
  ) else $error("mask read data wrong");

  a_first_held: assert property (
    !first_empty |=> ((first_q & ~$past(first_q)) == '0)
  ) else $error("first log gained a bit while occupied");

  a_first_group: assert property (
    (first_empty && recog != '0) |=> (first_q == $past(recog))
  ) else $error("same-clock errors not all in first log");

  a_rsvd_read_zero: assert property (
    reg_req.rd |=> (reg_rdata[wbe_pkg::WBE_DATA_W-1:NS]
                    == wbe_pkg::WBE_RSVD_VAL)
  ) else $error("reserved bits read nonzero");

  a_set_beats_clear: assert property (
    (next_set != '0 && wr_next) |=>
      ((next_q & $past(next_set)) == $past(next_set))
  ) else $error("error lost against clear");

  a_read_one_cycle: assert property (
    !reg_req.rd |=> (reg_rdata == wbe_pkg::WBE_RD_IDLE)
  ) else $error("read data outside its cycle");

  // ==========================================================================
  // Routing and register access checks
  // ==========================================================================
  // Event feed is recognition one cycle late, masked bits never reach it
  a_event_tracks_recog: assert property (
    1'b1 |=> (err_event == $past(recog))
  ) else $error("event output differs from recognised errors");

  // A next bit may only rise where routing sent an error
  a_next_no_stray: assert property (
    1'b1 |=>
      ((next_q & ~$past(next_q) & ~$past(next_set)) == '0)
  ) else $error("next log bit rose without a routed error");

  // While the first log is empty and next is not written, the next log must stay put
  a_next_idle_first: assert property (
    (first_empty && !wr_next) |=> (next_q == $past(next_q))
  ) else $error("first-clock error leaked into next log");

  // Clearing the first log reopens it for the next first error
  a_first_w1c_clear: assert property (
    (wr_first && (first_set & wdata_low) == '0) |=>
      ((first_q & $past(wdata_low)) == '0)
  ) else $error("first log bit not cleared by write of one");

  a_first_read_back: assert property (
    (reg_req.rd && sel_first) |=>
      (reg_rdata == {wbe_pkg::WBE_RSVD_VAL, $past(first_q)})
  ) else $error("first log read data wrong");

  a_next_read_back: assert property (
    (reg_req.rd && sel_next) |=>
      (reg_rdata == {wbe_pkg::WBE_RSVD_VAL, $past(next_q)})
  ) else $error("next log read data wrong");

  // Only the low nibble is stored, upper write bits are dropped
  a_mask_write_lands: assert property (
    wr_mask |=> (mask_reg == $past(wdata_low))
  ) else $error("mask write did not land");

  a_mask_holds_idle: assert property (
    !wr_mask |=> (mask_reg == $past(mask_reg))
  ) else $error("mask changed without a write");

  a_unmapped_reads_zero: assert property (
    (reg_req.rd && !sel_first && !sel_next && !sel_mask) |=>
      (reg_rdata == wbe_pkg::WBE_RD_IDLE)
  ) else $error("unmapped offset read nonzero");

  // Bus outputs go quiet under system reset, while the logs are untouched
  a_rst_quiet_outputs: assert property (
    @(posedge clk) disable iff (pwr_rst)
    sys_rst |=> (err_event == '0 && reg_rdata == wbe_pkg::WBE_RD_IDLE)
  ) else $error("bus outputs active during system reset");

  c_first_capture: cover property (first_empty && recog != '0);
  c_next_capture: cover property (!first_empty && recog != '0);
  c_clear_race: cover property (next_set != '0 && wr_next
                                && (next_set & wdata_low) != '0);
  c_masked_hit: cover property ((src_bits & mask_reg) != '0);
  c_first_clear: cover property (wr_first && (first_q & wdata_low) != '0);

endmodule

/* File: test/test_wbe_error_log.sv */
// Self-checking bench for the write buffer error log and mask bank
`timescale 1ns/1ps
module test_wbe_error_log;

  // ==========================================================================
  // Clock, reset and stimulus
  // ==========================================================================
  logic                            clk;
  logic                            sys_rst;
  logic                            pwr_rst;
  wbe_pkg::wbe_req_t               reg_req;
  logic [wbe_pkg::WBE_DATA_W-1:0]  reg_rdata;
  wbe_pkg::wbe_err_t               err_strobe;
  wbe_pkg::wbe_err_t               err_event;
  int                              err_count;
  int                              compares;
  int                              cycles;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  wbe_error_log wbe_error_log_inst (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pwr_rst    (pwr_rst),
    .reg_req    (reg_req),
    .reg_rdata  (reg_rdata),
    .err_strobe (err_strobe),
    .err_event  (err_event)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic stop_test();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One cycle of bus request and error strobes, then the event check
  task automatic cyc(input logic [7:0] a, input logic [7:0] d,
                     input logic w, input logic [3:0] e,
                     input logic [3:0] ev);
    reg_req    <= '{addr: a, wdata: d, wr: w, rd: 1'b0};
    err_strobe <= e;
    @(posedge clk);
    reg_req    <= '0;
    err_strobe <= '0;
    #1 chk({4'h0, err_event}, {4'h0, ev});
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1, 4'h0, 4'h0);
  endtask

  task automatic hit(input logic [3:0] e, input logic [3:0] ev);
    cyc(8'h00, 8'h00, 1'b0, e, ev);
  endtask

  // Data stands only in the cycle after the strobe, idle zero after that
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1 chk(reg_rdata, exp);
    @(posedge clk);
    #1 chk(reg_rdata, 8'h00);
    @(posedge clk);
  endtask

  task automatic hold_rst();
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    pwr_rst <= 1'b0;
    @(posedge clk);
  endtask

  // Hang guard, the whole sequence needs about 150 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    err_count  = 0;
    compares   = 0;
    cycles     = 0;
    sys_rst    = 1'b1;
    pwr_rst    = 1'b1;
    reg_req    = '0;
    err_strobe = '0;
    hold_rst();
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h00);
    rd(wbe_pkg::WBE_OFS_MASK, 8'h00);
    // Two sources in the first error's clock both go to the first log
    hit(4'h3, 4'h3);
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h03);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      hit(4'h1 << i, 4'h1 << i);
      rd(wbe_pkg::WBE_OFS_NEXT, 8'h01 << i);
      wr(wbe_pkg::WBE_OFS_NEXT, 8'h01 << i);
    end
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h03);
    hit(4'hF, 4'hF);
    // Ones clear, zeros and reserved bits do nothing
    wr(wbe_pkg::WBE_OFS_NEXT, 8'hF5);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h0A);
    wr(wbe_pkg::WBE_OFS_NEXT, 8'h00);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h0A);
    // New error on bit 1 while software clears bits 3 and 1
    cyc(wbe_pkg::WBE_OFS_NEXT, 8'h0A, 1'b1, 4'h2, 4'h2);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h02);
    wr(wbe_pkg::WBE_OFS_MASK, 8'hF5);
    rd(wbe_pkg::WBE_OFS_MASK, 8'h05);
    // System reset leaves logs and mask alone
    sys_rst <= 1'b1;
    hold_rst();
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h02);
    rd(wbe_pkg::WBE_OFS_MASK, 8'h05);
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h03);
    // Masked sources produce neither a log bit nor an event
    wr(wbe_pkg::WBE_OFS_NEXT, 8'h0F);
    hit(4'hF, 4'hA);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h0A);
    wr(wbe_pkg::WBE_OFS_FIRST, 8'h03);
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h00);
    hit(4'h1, 4'h0);
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h00);
    hit(4'h4, 4'h0);
    hit(4'h8, 4'h8);
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h08);
    // Empty next log first, so the later error is seen on its own
    wr(wbe_pkg::WBE_OFS_NEXT, 8'h0F);
    hit(4'h2, 4'h2);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h02);
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h08);
    // Unmapped and reserved offsets read zero and take no write
    wr(8'h76, 8'hFF);
    rd(8'h76, 8'h00);
    rd(8'h71, 8'h00);
    wr(wbe_pkg::WBE_OFS_MASK, 8'h00);
    hit(4'h5, 4'h5);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h07);
    // Power-up reset zeroes both logs and the mask
    wr(wbe_pkg::WBE_OFS_MASK, 8'h0A);
    pwr_rst <= 1'b1;
    hold_rst();
    rd(wbe_pkg::WBE_OFS_FIRST, 8'h00);
    rd(wbe_pkg::WBE_OFS_NEXT, 8'h00);
    rd(wbe_pkg::WBE_OFS_MASK, 8'h00);
    stop_test();
  end

endmodule
